// ### src/dds_nco_phase_modulator.sv
// NCO core: write port, phase accumulator, phase offset and sine table
//
// Summary of operation
// RULE_01 - Two 32-bit steps, select picks one
// RULE_02 - Four 12-bit offsets chosen by two selects
// RULE_03 - Address 0-3 freq halves, 4-7 offsets
// RULE_04 - Offset writes keep data bits 11..0
// RULE_05 - Data bit 15 is half-word MSB
// RULE_06 - 32-bit accumulator wraps naturally
// RULE_07 - Accumulator adds selected step each cycle
// RULE_08 - Step changes never disturb accumulator value
// RULE_09 - Offset added to accumulator top bits
// RULE_10 - Top 12 phase bits address sine table
// RULE_11 - Table yields 10-bit amplitude code
// RULE_12 - Write reaches register after strobe rise
// RULE_13 - Selects sampled only on clock edges
// RULE_14 - Six cycles from select to amplitude
// RULE_15 - Clear zeroes accumulator, registers kept
// RULE_16 - Strobe rise latches into holding stage
// RULE_17 - Offset-binary amplitude, zero phase midscale
`timescale 1ns/1ps
`include "nco_params.svh"
module dds_nco_phase_modulator
	import nco_pkg::*;
#(
	parameter int FIFO_DEPTH = `NCO_FIFO_DEPTH
) (
	input  wire logic                   ref_clk_i,
	input  wire logic                   rst_i,
	input  wire logic                   accum_clear_n_i,
	input  wire logic                   wr_strobe_n_i,
	input  wire logic [`NCO_ADDR_W-1:0] reg_select_addr_i,
	input  wire logic [`NCO_DATA_W-1:0] host_data_bus_i,
	input  wire logic                   commit_hold_i,
	input  wire logic                   freq_word_select_i,
	input  wire logic                   phase_index_low_i,
	input  wire logic                   phase_index_high_i,
	output logic      [`NCO_AMP_W-1:0]  amplitude_o,
	output logic                        wr_ready_o
);
	localparam int EW = $bits(write_entry_t);

	write_req_if #(.WIDTH(EW)) wq ();

	logic                    strobe_prev_reg;
	logic                    strobe_rise;
	logic                    hold_valid_reg;
	write_entry_t            hold_reg;
	write_entry_t            commit_entry;
	logic                    commit_fire;
	logic [`NCO_ACC_W-1:0]   word_a_reg;
	logic [`NCO_ACC_W-1:0]   word_b_reg;
	logic [`NCO_PHASE_W-1:0] phase_off_reg [4];
	logic [`NCO_ACC_W-1:0]   step_reg;
	logic [`NCO_PHASE_W-1:0] off_sel_reg;
	logic [`NCO_PHASE_W-1:0] off_d_reg;
	logic [`NCO_ACC_W-1:0]   acc_reg;
	logic [`NCO_PHASE_W-1:0] sum_reg;
	logic [`NCO_PHASE_W-1:0] lut_addr_reg;
	logic [`NCO_AMP_W-1:0]   rom_data_reg;
	logic [2:0]              warm_reg;

	// Sine of a 12-bit phase, offset binary; rational fit avoids a 4096-entry ROM
	function automatic logic [`NCO_AMP_W-1:0] sine_code(
		input logic [`NCO_PHASE_W-1:0] ph
	);
		logic [39:0] h;
		logic [39:0] t;
		logic [39:0] den;
		logic [39:0] amp;
		h   = 40'(ph[`NCO_PHASE_W-2:0]);
		t   = h * (`NCO_HALF_SPAN - h);
		den = `NCO_BHASKARA_DEN - (t << 2);
		amp = (t * `NCO_SINE_GAIN + (den >> 1)) / den;
		if (ph[`NCO_PHASE_W-1]) begin
			sine_code = `NCO_NEG_BASE - amp[`NCO_AMP_W-1:0];
		end else begin
			sine_code = `NCO_MIDSCALE + amp[`NCO_AMP_W-1:0];
		end
	endfunction

	// Phase adder is modulo 2^12 so the offset wraps with the cycle
	function automatic logic [`NCO_PHASE_W-1:0] phase_add(
		input logic [`NCO_ACC_W-1:0]   acc,
		input logic [`NCO_PHASE_W-1:0] off
	);
		phase_add = acc[`NCO_ACC_W-1 -: `NCO_PHASE_W] + off;
	endfunction

	// Host strobe edge into the holding stage
	assign strobe_rise = wr_strobe_n_i && !strobe_prev_reg;

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			strobe_prev_reg <= 1'b1;
		end else begin
			strobe_prev_reg <= wr_strobe_n_i;
		end
	end

	// A new rise overwrites a stalled entry; wr_ready_o warns the host first
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			hold_valid_reg <= 1'b0;
			hold_reg       <= '0;
		end else if (strobe_rise) begin
			hold_valid_reg <= 1'b1; // RULE_16
			hold_reg       <= {dest_t'(reg_select_addr_i), host_data_bus_i}; // RULE_16
		end else if (wq.push_ready) begin
			hold_valid_reg <= 1'b0;
		end
	end

	assign wq.push_valid = hold_valid_reg;
	assign wq.push_data  = hold_reg;
	assign wq.pop_ready  = !commit_hold_i;
	assign commit_entry  = write_entry_t'(wq.pop_data);
	assign commit_fire   = wq.pop_valid && !commit_hold_i;

	write_fifo #(
		.WIDTH(EW),
		.DEPTH(FIFO_DEPTH)
	) u_write_fifo (
		.ref_clk_i(ref_clk_i),
		.rst_i    (rst_i),
		.q        (wq)
	);

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			wr_ready_o <= 1'b0;
		end else begin
			wr_ready_o <= wq.push_ready && !hold_valid_reg;
		end
	end

	// Destination decode; registers keep contents through reset
	always_ff @(posedge ref_clk_i) begin
		if (commit_fire) begin // RULE_12
			if (commit_entry.dest == DEST_A_LO) begin // RULE_03
				word_a_reg[15:0] <= commit_entry.data; // RULE_05
			end else if (commit_entry.dest == DEST_A_HI) begin
				word_a_reg[31:16] <= commit_entry.data; // RULE_05
			end else if (commit_entry.dest == DEST_B_LO) begin
				word_b_reg[15:0] <= commit_entry.data;
			end else if (commit_entry.dest == DEST_B_HI) begin
				word_b_reg[31:16] <= commit_entry.data;
			end else begin
				phase_off_reg[commit_entry.dest[1:0]] <=
					commit_entry.data[`NCO_PHASE_W-1:0]; // RULE_04
			end
		end
	end

	// Selects sampled on the edge, then pipelined to stay aligned
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			step_reg    <= `NCO_ACC_RESET;
			off_sel_reg <= '0;
			off_d_reg   <= '0;
		end else begin
			step_reg    <= freq_word_select_i ? word_b_reg : word_a_reg; // RULE_01 RULE_13
			off_sel_reg <= phase_off_reg[{phase_index_high_i, phase_index_low_i}]; // RULE_02
			off_d_reg   <= off_sel_reg;
		end
	end

	// Only the step feeds in, so switching keeps phase continuous
	always_ff @(posedge ref_clk_i) begin
		if (rst_i || !accum_clear_n_i) begin
			acc_reg <= `NCO_ACC_RESET; // RULE_15
		end else begin
			acc_reg <= acc_reg + step_reg; // RULE_06 RULE_07 RULE_08
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			sum_reg      <= '0;
			lut_addr_reg <= '0;
			rom_data_reg <= `NCO_MIDSCALE;
			amplitude_o  <= `NCO_MIDSCALE;
		end else begin
			sum_reg      <= phase_add(acc_reg, off_d_reg); // RULE_09
			lut_addr_reg <= sum_reg; // RULE_10
			rom_data_reg <= sine_code(lut_addr_reg); // RULE_11 RULE_17
			amplitude_o  <= rom_data_reg; // RULE_14
		end
	end

	// Helper for assertions: pipeline history valid after reset
	// Clear restarts it; registers may be unwritten until the first clear ends
	always_ff @(posedge ref_clk_i) begin
		if (rst_i || !accum_clear_n_i) begin
			warm_reg <= '0;
		end else if (warm_reg != `NCO_WARM_MAX) begin
			warm_reg <= warm_reg + 1'b1;
		end
	end

	AST_STEP_SELECT: assert property ( // RULE_01
		@(posedge ref_clk_i) disable iff (rst_i)
		warm_reg == `NCO_WARM_MAX |-> step_reg ==
			($past(freq_word_select_i) ? $past(word_b_reg) : $past(word_a_reg)))
		else $error("step word does not follow frequency select");

	AST_OFFSET_SELECT: assert property ( // RULE_02
		@(posedge ref_clk_i) disable iff (rst_i)
		warm_reg == `NCO_WARM_MAX |-> off_sel_reg ==
			$past(phase_off_reg[{phase_index_high_i, phase_index_low_i}]))
		else $error("phase offset does not follow phase index");

	AST_FREQ_HIGH_HALF: assert property ( // RULE_03
		@(posedge ref_clk_i) disable iff (rst_i)
		commit_fire && commit_entry.dest == DEST_B_HI |=>
			word_b_reg[31:16] == $past(commit_entry.data) &&
			$stable(word_a_reg))
		else $error("high half of second step word misrouted");

	AST_PHASE_LOW_BITS: assert property ( // RULE_04
		@(posedge ref_clk_i) disable iff (rst_i)
		commit_fire && commit_entry.dest == DEST_PHASE2 |=>
			phase_off_reg[2] == $past(commit_entry.data[`NCO_PHASE_W-1:0]))
		else $error("phase offset write lost its low twelve bits");

	AST_ACC_ADVANCE: assert property ( // RULE_07
		@(posedge ref_clk_i) disable iff (rst_i)
		warm_reg == `NCO_WARM_MAX && accum_clear_n_i |=>
			acc_reg == $past(acc_reg) + $past(step_reg))
		else $error("accumulator did not add the step");

	AST_ACC_CLEAR: assert property ( // RULE_15
		@(posedge ref_clk_i) disable iff (rst_i)
		!accum_clear_n_i ##1 accum_clear_n_i |->
			acc_reg == `NCO_ACC_RESET && $stable(word_a_reg))
		else $error("clear did not zero only the accumulator");

	AST_PHASE_SUM: assert property ( // RULE_09
		@(posedge ref_clk_i) disable iff (rst_i)
		warm_reg == `NCO_WARM_MAX |-> sum_reg ==
			$past(acc_reg[`NCO_ACC_W-1 -: `NCO_PHASE_W]) + $past(off_d_reg))
		else $error("offset not added to accumulator top bits");

	AST_OUTPUT_LATENCY: assert property ( // RULE_14
		@(posedge ref_clk_i) disable iff (rst_i)
		warm_reg == `NCO_WARM_MAX |-> amplitude_o == sine_code($past(sum_reg, 3)))
		else $error("amplitude not aligned with phase pipeline");

	AST_STROBE_CAPTURE: assert property ( // RULE_16
		@(posedge ref_clk_i) disable iff (rst_i)
		strobe_rise |=> hold_valid_reg &&
			hold_reg == $past({reg_select_addr_i, host_data_bus_i}))
		else $error("strobe edge did not latch address and data");

	AST_MIDSCALE_ZERO: assert property ( // RULE_17
		@(posedge ref_clk_i) disable iff (rst_i)
		lut_addr_reg == '0 |=> rom_data_reg == `NCO_MIDSCALE)
		else $error("zero phase did not give midscale");

	// Write path, accumulator and table address edge cases
	AST_FREQ_LOW_HALF: assert property ( // RULE_05
		@(posedge ref_clk_i) disable iff (rst_i)
		commit_fire && commit_entry.dest == DEST_A_LO |=>
			word_a_reg[15:0] == $past(commit_entry.data))
		else $error("low half of first step word misrouted");

	AST_OFFSET_COMMIT: assert property ( // RULE_03
		@(posedge ref_clk_i) disable iff (rst_i)
		commit_fire && commit_entry.dest == DEST_PHASE0 |=>
			phase_off_reg[0] == $past(commit_entry.data[`NCO_PHASE_W-1:0]))
		else $error("write to first phase offset misrouted");

	AST_ACC_WRAP: assert property ( // RULE_06
		@(posedge ref_clk_i) disable iff (rst_i)
		warm_reg == `NCO_WARM_MAX && accum_clear_n_i && acc_reg > ~step_reg |=>
			acc_reg < $past(acc_reg))
		else $error("accumulator did not wrap past full scale");

	AST_STEP_SWITCH: assert property ( // RULE_08
		@(posedge ref_clk_i) disable iff (rst_i)
		warm_reg == `NCO_WARM_MAX && accum_clear_n_i && $changed(step_reg) |=>
			acc_reg == $past(acc_reg) + $past(step_reg))
		else $error("step change disturbed the accumulator");

	AST_STEP_STEADY: assert property ( // RULE_13
		@(posedge ref_clk_i) disable iff (rst_i)
		warm_reg == `NCO_WARM_MAX && $stable(freq_word_select_i) &&
			$stable(word_a_reg) && $stable(word_b_reg) |=> $stable(step_reg))
		else $error("step word moved without a sampled change");

	AST_TABLE_ADDR: assert property ( // RULE_10
		@(posedge ref_clk_i) disable iff (rst_i)
		warm_reg == `NCO_WARM_MAX |-> lut_addr_reg == $past(sum_reg))
		else $error("table address is not the truncated phase");

	AST_HOLD_DRAIN: assert property ( // RULE_12
		@(posedge ref_clk_i) disable iff (rst_i)
		hold_valid_reg && wq.push_ready && !strobe_rise |=> !hold_valid_reg)
		else $error("held write did not move on toward its register");

	AST_READY_WARNS: assert property ( // RULE_16
		@(posedge ref_clk_i) disable iff (rst_i)
		hold_valid_reg || !wq.push_ready |=> !wr_ready_o)
		else $error("write ready shown while the holding stage is busy");

	AST_CLEAR_LEVEL: assert property ( // RULE_15
		@(posedge ref_clk_i) disable iff (rst_i)
		!accum_clear_n_i |=> acc_reg == `NCO_ACC_RESET)
		else $error("accumulator not held at zero while clear is low");
endmodule

// ### src/nco_params.svh
// Constants for the phase-modulated NCO core
`ifndef NCO_PARAMS_SVH
`define NCO_PARAMS_SVH

`define NCO_ACC_W        32
`define NCO_PHASE_W      12
`define NCO_AMP_W        10
`define NCO_DATA_W       16
`define NCO_ADDR_W       3
`define NCO_FIFO_DEPTH   32
`define NCO_LATENCY      6
`define NCO_ACC_RESET    32'h0000_0000
`define NCO_MIDSCALE     10'h200
`define NCO_NEG_BASE     10'h1FF
`define NCO_SINE_GAIN    40'h00_0000_1FF0
`define NCO_HALF_SPAN    40'h00_0000_0800
`define NCO_BHASKARA_DEN 40'h00_0140_0000
`define NCO_WARM_MAX     3'h7

`endif

// ### src/nco_pkg.sv
// Types shared by the NCO core and its write queue
package nco_pkg;

	typedef enum logic [2:0] {
		DEST_A_LO   = 3'h0,
		DEST_A_HI   = 3'h1,
		DEST_B_LO   = 3'h2,
		DEST_B_HI   = 3'h3,
		DEST_PHASE0 = 3'h4,
		DEST_PHASE1 = 3'h5,
		DEST_PHASE2 = 3'h6,
		DEST_PHASE3 = 3'h7
	} dest_t;

	typedef struct packed {
		dest_t       dest;
		logic [15:0] data;
	} write_entry_t;

endpackage

// ### src/write_req_if.sv
// Valid/ready carrier between the core and its write queue
`timescale 1ns/1ps
interface write_req_if #(
	parameter int WIDTH = 19
);
	logic [WIDTH-1:0] push_data;
	logic             push_valid;
	logic             push_ready;
	logic [WIDTH-1:0] pop_data;
	logic             pop_valid;
	logic             pop_ready;

	modport queue (
		input  push_data,
		input  push_valid,
		output push_ready,
		output pop_data,
		output pop_valid,
		input  pop_ready
	);

	modport user (
		output push_data,
		output push_valid,
		input  push_ready,
		input  pop_data,
		input  pop_valid,
		output pop_ready
	);
endinterface

// ### src/write_fifo.sv
// Parameterised FIFO with registered read data
`timescale 1ns/1ps
module write_fifo #(
	parameter int WIDTH = 19,
	parameter int DEPTH = 32
) (
	input wire logic   ref_clk_i,
	input wire logic   rst_i,
	write_req_if.queue q
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	logic [AW:0]      count_next;
	logic             full_reg;
	logic             out_valid_reg;
	logic [WIDTH-1:0] out_data_reg;
	logic             push_fire;
	logic             mem_rd;

	assign push_fire    = q.push_valid && !full_reg;
	// Out stage refills whenever empty or being taken
	assign mem_rd       = (count_reg != '0) && (!out_valid_reg || q.pop_ready);
	assign q.push_ready = !full_reg;
	assign q.pop_valid  = out_valid_reg;
	assign q.pop_data   = out_data_reg;

	always_comb begin
		count_next = count_reg;
		if (push_fire && !mem_rd) begin
			count_next = count_reg + 1'b1;
		end else if (!push_fire && mem_rd) begin
			count_next = count_reg - 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (push_fire) begin
			mem[wr_ptr_reg] <= q.push_data;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
			full_reg   <= 1'b0;
		end else begin
			if (push_fire) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (mem_rd) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
			count_reg <= count_next;
			full_reg  <= (count_next == (AW+1)'(DEPTH));
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			out_valid_reg <= 1'b0;
			out_data_reg  <= '0;
		end else if (mem_rd) begin
			out_valid_reg <= 1'b1;
			out_data_reg  <= mem[rd_ptr_reg];
		end else if (q.pop_ready) begin
			out_valid_reg <= 1'b0;
		end
	end
endmodule

// ### testbench/host_writer.sv
// Host model that loads the NCO registers over the parallel write port
`timescale 1ns/1ps
module host_writer (
	input  wire logic        ref_clk_i,
	input  wire logic        wr_ready_i,
	output logic             wr_strobe_n_o,
	output logic [2:0]       reg_select_addr_o,
	output logic [15:0]      host_data_bus_o
);
	initial begin
		wr_strobe_n_o = 1'b1;
		reg_select_addr_o = 3'h0;
		host_data_bus_o = 16'h0000;
	end

	// Waits for room, then one low-high strobe; held until the rise is sampled
	task automatic put_word(input logic [2:0] addr, input logic [15:0] data);
		int n;
		n = 0;
		do begin
			@(posedge ref_clk_i);
			#1;
			n++;
		end while (wr_ready_i !== 1'b1 && n < 200);
		wr_strobe_n_o = 1'b0;
		reg_select_addr_o = addr;
		host_data_bus_o = data;
		@(posedge ref_clk_i);
		#1;
		wr_strobe_n_o = 1'b1;
		@(posedge ref_clk_i);
		#1;
		// Released bus shows no stale value
		host_data_bus_o = ~data;
		reg_select_addr_o = ~addr;
	endtask
endmodule

// ### testbench/tb_top.sv
// Self-checking bench for the phase-modulated NCO core
`timescale 1ns/1ps
module tb_top;
	typedef struct packed {
		logic [1:0] idx;
		logic [9:0] amp;
	} row_t;

	localparam int DEPTH = 4;
	logic        ref_clk;
	logic        rst;
	logic        clear_n;
	logic        strobe_n;
	logic [2:0]  addr;
	logic [15:0] data;
	logic        hold;
	logic        fsel;
	logic [1:0]  pidx;
	logic [9:0]  amp;
	logic        ready;
	logic [9:0]  a;
	int          n;
	int          cycles;
	int          mismatches;
	int          check_count;
	logic [15:0] init_words [8] = '{16'h0000, 16'h0000, 16'h0000, 16'h4000,
		16'h0000, 16'hF400, 16'hA800, 16'h5C00};
	// Quarter-turn offsets give exact codes, no sine model needed
	row_t        rows [4] = '{'{2'h0, 10'h200}, '{2'h1, 10'h3FF},
		'{2'h2, 10'h1FF}, '{2'h3, 10'h000}};

	dds_nco_phase_modulator #(.FIFO_DEPTH(DEPTH)) dds_nco_phase_modulator_inst (
		.ref_clk_i          (ref_clk),
		.rst_i              (rst),
		.accum_clear_n_i    (clear_n),
		.wr_strobe_n_i      (strobe_n),
		.reg_select_addr_i  (addr),
		.host_data_bus_i    (data),
		.commit_hold_i      (hold),
		.freq_word_select_i (fsel),
		.phase_index_low_i  (pidx[0]),
		.phase_index_high_i (pidx[1]),
		.amplitude_o        (amp),
		.wr_ready_o         (ready)
	);

	host_writer host_writer_inst (
		.ref_clk_i         (ref_clk),
		.wr_ready_i        (ready),
		.wr_strobe_n_o     (strobe_n),
		.reg_select_addr_o (addr),
		.host_data_bus_o   (data)
	);

	initial ref_clk = 1'b0;
	always #4 ref_clk = ~ref_clk;

	function automatic logic [9:0] next_amp(input logic [9:0] v);
		case (v)
			10'h200: next_amp = 10'h3FF;
			10'h3FF: next_amp = 10'h1FF;
			10'h1FF: next_amp = 10'h000;
			default: next_amp = 10'h200;
		endcase
	endfunction

	task automatic tick(input int k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		check_count++;
		if (seen !== want) begin
			mismatches++;
			$display("BAD t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask

	task automatic give_verdict();
		if (mismatches == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Whole run needs well under a thousand cycles
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			give_verdict();
		end
	end

	initial begin
		rst = 1'b1;
		clear_n = 1'b0;
		hold = 1'b0;
		fsel = 1'b0;
		pidx = 2'h0;
		tick(3);
		check(16'(amp), 16'h0200);
		check(16'(ready), 16'h0000);
		rst = 1'b0;
		// Write port is free from the first edge after release
		tick(1);
		check(16'(ready), 16'h0001);
		tick(1);
		check(16'(ready), 16'h0001);
		// Registers power up unknown: load all eight with the accumulator held clear
		for (int i = 0; i < 8; i++) begin
			host_writer_inst.put_word(3'(i), init_words[i]);
		end
		tick(8);
		clear_n = 1'b1;
		foreach (rows[i]) begin
			pidx = rows[i].idx;
			tick(8);
			check(16'(amp), 16'(rows[i].amp));
		end
		pidx = 2'h1;
		tick(5);
		check(16'(amp), 16'h0000);
		tick(1);
		check(16'(amp), 16'h03FF);
		pidx = 2'h0;
		tick(8);
		fsel = 1'b1;
		tick(5);
		a = 10'h200;
		repeat (8) begin
			check(16'(amp), 16'(a));
			tick(1);
			a = next_amp(a);
		end
		fsel = 1'b0;
		tick(8);
		check(16'(amp), 16'(next_amp(a)));
		tick(1);
		check(16'(amp), 16'(next_amp(a)));
		fsel = 1'b1;
		clear_n = 1'b0;
		tick(8);
		check(16'(amp), 16'h0200);
		fsel = 1'b0;
		tick(2);
		clear_n = 1'b1;
		pidx = 2'h1;
		tick(8);
		check(16'(amp), 16'h03FF);
		pidx = 2'h0;
		hold = 1'b1;
		n = 0;
		while (ready === 1'b1 && n < 40) begin
			host_writer_inst.put_word(3'h4, n[0] ? 16'h0800 : 16'h0400);
			tick(2);
			n++;
		end
		check(16'(ready), 16'h0000);
		check(16'(amp), 16'h0200);
		hold = 1'b0;
		tick(3 * DEPTH + 20);
		check(16'(ready), 16'h0001);
		check(16'(amp), (n % 2 == 0) ? 16'h01FF : 16'h03FF);
		give_verdict();
	end
endmodule
